// *** qhs_host_port.sv ***
// How it works
// - 8-bit data bus, 3 address lines, strobes
// - Bus cycles need only selects, strobes, address
// - One shared data bus; decode picks channel
// - Reset restores every channel register default
// - Strobe style: per-channel selects pick A-D
// - Writes reach all selected; never multi-read
// - Line style: select plus two bits pick channel
// - Channel address bits used only in line style
// - Each channel owns a full register set
// - Transmit interrupt follows empty or trigger level
// - Receive interrupt follows data or trigger level
// - Block mode bit only changes ready outputs
// - Fifo without block mode is single-character
// - Receive ready low while any byte held
// - Block receive ready: falls at trigger, rises empty
// - Transmit ready low only when transmit empty
// - Block transmit ready high only when full
// - Line status 5,6 pace transmit block loads
// - Strobe style interrupt gated by MCR bit 3 unless style pin high
// - Status 5 fifo empty, 6 all empty
module qhs_host_port (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Host bus
    input wire qhs_pkg::qhs_bus_t host_bus,
    output logic [7:0] rdata,
    output logic rdata_oe,
    // Interrupt style pin
    input wire logic irq_style_select,
    // Channel datapath status
    input wire qhs_pkg::qhs_chan_stat_t [3:0] chan_stat,
    // Channel datapath control
    output qhs_pkg::qhs_chan_regs_t [3:0] chan_cfg,
    output logic [7:0] tx_byte,
    output logic [3:0] tx_load,
    output logic [3:0] rx_unload,
    // Per-channel pins
    output logic [3:0] irq,
    output logic [3:0] rx_ready_n,
    output logic [3:0] tx_ready_n
);

    // ==========================================================
    // Helpers
    // ==========================================================
    // Line status byte of one channel
    function automatic logic [7:0] line_status_of(input qhs_pkg::qhs_chan_stat_t s);
        logic [7:0] v;
        v = 8'h00;
        v[qhs_pkg::LSR_DATA_READY] = (s.rx_level != 5'h00);
        v[qhs_pkg::LSR_TX_HOLD_EMPTY] = (s.tx_level == 5'h00);
        v[qhs_pkg::LSR_TX_ALL_EMPTY] = (s.tx_level == 5'h00) && s.tsr_empty;
        return v;
    endfunction : line_status_of

    // Transmit interrupt condition
    function automatic logic tx_irq_of(input qhs_pkg::qhs_chan_regs_t r,
                                       input qhs_pkg::qhs_chan_stat_t s);
        logic empty;
        empty = (s.tx_level == 5'h00);
        if (r.fifo_control[qhs_pkg::FCR_FIFO_EN]) begin
            return empty || (s.tx_level < s.tx_trig);
        end
        return empty;
    endfunction : tx_irq_of

    // Receive interrupt condition
    function automatic logic rx_irq_of(input qhs_pkg::qhs_chan_regs_t r,
                                       input qhs_pkg::qhs_chan_stat_t s);
        if (r.fifo_control[qhs_pkg::FCR_FIFO_EN]) begin
            return (s.rx_level >= s.rx_trig) || s.rx_timeout;
        end
        return (s.rx_level != 5'h00);
    endfunction : rx_irq_of

    // Block mode is active only with the fifos on
    function automatic logic block_mode_of(input qhs_pkg::qhs_chan_regs_t r);
        return r.fifo_control[qhs_pkg::FCR_FIFO_EN] && r.fifo_control[qhs_pkg::FCR_BLOCK];
    endfunction : block_mode_of

    // Register read of one channel
    function automatic logic [7:0] read_of(input qhs_pkg::qhs_chan_regs_t r,
                                           input qhs_pkg::qhs_chan_stat_t s,
                                           input logic [2:0] a);
        logic [7:0] v;
        logic dl;
        v = 8'h00;
        dl = r.line_control[qhs_pkg::LCR_DIV_ACCESS];
        case (a)
            qhs_pkg::OFS_DATA: v = dl ? r.divisor_low : s.rx_byte;
            qhs_pkg::OFS_IER: v = dl ? r.divisor_high : r.irq_enable;
            qhs_pkg::OFS_FCR: begin
                if (r.irq_enable[qhs_pkg::IER_RX] && rx_irq_of(r, s)) begin
                    v = qhs_pkg::IDENT_RX;
                end else if (r.irq_enable[qhs_pkg::IER_TX] && tx_irq_of(r, s)) begin
                    v = qhs_pkg::IDENT_TX;
                end else begin
                    v = qhs_pkg::IDENT_NONE;
                end
                v[qhs_pkg::IDENT_FIFO_LO] = r.fifo_control[qhs_pkg::FCR_FIFO_EN];
                v[qhs_pkg::IDENT_FIFO_HI] = r.fifo_control[qhs_pkg::FCR_FIFO_EN];
            end
            qhs_pkg::OFS_LCR: v = r.line_control;
            qhs_pkg::OFS_MCR: v = r.modem_control;
            qhs_pkg::OFS_LSR: v = line_status_of(s);
            qhs_pkg::OFS_MSR: v = s.modem_in;
            qhs_pkg::OFS_SPR: v = r.scratch_byte;
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_of

    // ==========================================================
    // State
    // ==========================================================
    qhs_pkg::qhs_state_t q;
    qhs_pkg::qhs_state_t d;

    // Bus decode terms
    logic [3:0] sel;
    logic rd_act;
    logic wr_act;
    logic wr_take;
    logic rd_take;
    logic [1:0] rd_chan;

    // ==========================================================
    // Bus decode
    // ==========================================================
    // Channel select and strobes for the two bus styles
    always_comb begin
        sel = 4'h0;
        rd_act = 1'b0;
        wr_act = 1'b0;
        if (host_bus.bus_style_sel) begin
            // Separate strobes, one select per channel
            sel[0] = !host_bus.chan_a_select_n;
            sel[1] = !host_bus.chan_b_select_n;
            sel[2] = !host_bus.chan_c_select_n;
            sel[3] = !host_bus.chan_d_select_n;
            rd_act = !host_bus.read_strobe_n && (sel != 4'h0);
            wr_act = !host_bus.write_strobe_n && (sel != 4'h0);
        end else if (!host_bus.chip_select_n) begin
            // Read/write line, channel from the two address bits
            case ({host_bus.chan_addr_hi, host_bus.chan_addr_lo})
                2'b00: sel = 4'h1;
                2'b01: sel = 4'h2;
                2'b10: sel = 4'h4;
                2'b11: sel = 4'h8;
                default: sel = 4'h0;
            endcase
            rd_act = host_bus.read_write_n;
            wr_act = !host_bus.read_write_n;
        end
    end

    // Take each strobe once, at its leading edge
    assign wr_take = wr_act && !q.wr_prev;
    assign rd_take = rd_act && !q.rd_prev;

    // Lowest selected channel answers a read
    always_comb begin
        rd_chan = 2'd0;
        for (int i = qhs_pkg::NUM_CHAN - 1; i >= 0; i--) begin
            if (sel[i]) begin
                rd_chan = 2'(i);
            end
        end
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        d = q;
        d.wr_prev = wr_act;
        d.rd_prev = rd_act;
        d.tx_load = 4'h0;
        d.rx_unload = 4'h0;

        // Read data onto the shared bus
        d.rdata_oe = rd_act;
        d.rdata = rd_act ? read_of(q.chans[rd_chan], chan_stat[rd_chan],
                                   host_bus.reg_addr) : 8'h00;

        for (int i = 0; i < qhs_pkg::NUM_CHAN; i++) begin
            // Register writes, to every selected channel
            if (wr_take && sel[i]) begin
                case (host_bus.reg_addr)
                    qhs_pkg::OFS_DATA: begin
                        if (q.chans[i].line_control[qhs_pkg::LCR_DIV_ACCESS]) begin
                            d.chans[i].divisor_low = host_bus.wdata;
                        end else begin
                            d.tx_load[i] = 1'b1;
                            d.tx_byte = host_bus.wdata;
                        end
                    end
                    qhs_pkg::OFS_IER: begin
                        if (q.chans[i].line_control[qhs_pkg::LCR_DIV_ACCESS]) begin
                            d.chans[i].divisor_high = host_bus.wdata;
                        end else begin
                            d.chans[i].irq_enable = host_bus.wdata;
                        end
                    end
                    qhs_pkg::OFS_FCR: d.chans[i].fifo_control = host_bus.wdata;
                    qhs_pkg::OFS_LCR: d.chans[i].line_control = host_bus.wdata;
                    qhs_pkg::OFS_MCR: d.chans[i].modem_control = host_bus.wdata;
                    qhs_pkg::OFS_SPR: d.chans[i].scratch_byte = host_bus.wdata;
                    default: d.chans[i].scratch_byte = q.chans[i].scratch_byte;
                endcase
            end

            // Reading the receive holding register pops one byte
            if (rd_take && sel[i] && (host_bus.reg_addr == qhs_pkg::OFS_DATA) &&
                !q.chans[i].line_control[qhs_pkg::LCR_DIV_ACCESS]) begin
                d.rx_unload[i] = 1'b1;
            end

            // Block receive ready: falls at trigger or timeout, rises when empty
            if (chan_stat[i].rx_level == 5'h00) begin
                d.chans[i].rx_blk_n = 1'b1;
            end else if ((chan_stat[i].rx_level >= chan_stat[i].rx_trig) ||
                         chan_stat[i].rx_timeout) begin
                d.chans[i].rx_blk_n = 1'b0;
            end

            // Ready outputs, from this channel's own levels only
            if (block_mode_of(q.chans[i])) begin
                d.rx_ready_n[i] = d.chans[i].rx_blk_n;
                d.tx_ready_n[i] = (chan_stat[i].tx_level == qhs_pkg::FIFO_FULL);
            end else begin
                d.rx_ready_n[i] = (chan_stat[i].rx_level == 5'h00);
                d.tx_ready_n[i] = (chan_stat[i].tx_level != 5'h00);
            end

            // Interrupt pin, optionally gated in the strobe style
            d.irq[i] = (q.chans[i].irq_enable[qhs_pkg::IER_TX] &&
                        tx_irq_of(q.chans[i], chan_stat[i])) ||
                       (q.chans[i].irq_enable[qhs_pkg::IER_RX] &&
                        rx_irq_of(q.chans[i], chan_stat[i]));
            if (host_bus.bus_style_sel && !irq_style_select) begin
                d.irq[i] = d.irq[i] && q.chans[i].modem_control[qhs_pkg::MCR_IRQ_GATE];
            end
        end

        // Reset returns every channel to its defaults
        if (!rstn) begin
            d = '0;
            d.rx_ready_n = 4'hf;
            d.tx_ready_n = 4'h0;
            for (int i = 0; i < qhs_pkg::NUM_CHAN; i++) begin
                d.chans[i].irq_enable = qhs_pkg::REG_RST;
                d.chans[i].fifo_control = qhs_pkg::REG_RST;
                d.chans[i].line_control = qhs_pkg::REG_RST;
                d.chans[i].modem_control = qhs_pkg::REG_RST;
                d.chans[i].scratch_byte = qhs_pkg::REG_RST;
                d.chans[i].divisor_low = qhs_pkg::DIV_LOW_RST;
                d.chans[i].divisor_high = qhs_pkg::DIV_HIGH_RST;
                d.chans[i].rx_blk_n = 1'b1;
            end
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        q <= d;
    end

    // ==========================================================
    // Outputs straight from the state
    // ==========================================================
    assign rdata = q.rdata;
    assign rdata_oe = q.rdata_oe;
    assign chan_cfg = q.chans;
    assign tx_byte = q.tx_byte;
    assign tx_load = q.tx_load;
    assign rx_unload = q.rx_unload;
    assign irq = q.irq;
    assign rx_ready_n = q.rx_ready_n;
    assign tx_ready_n = q.tx_ready_n;

endmodule : qhs_host_port

// *** qhs_pkg.sv ***
package qhs_pkg;

    // ==========================================================
    // Sizes
    localparam int NUM_CHAN = 4;
    localparam int LEVEL_W = 5;
    localparam logic [4:0] FIFO_FULL = 5'h10;

    // ==========================================================
    // Register offsets within one channel
    localparam logic [2:0] OFS_DATA = 3'h0; // Holding regs, or divisor low
    localparam logic [2:0] OFS_IER = 3'h1; // Irq enable, or divisor high
    localparam logic [2:0] OFS_FCR = 3'h2; // Fifo control on write, irq ident on read
    localparam logic [2:0] OFS_LCR = 3'h3;
    localparam logic [2:0] OFS_MCR = 3'h4;
    localparam logic [2:0] OFS_LSR = 3'h5;
    localparam logic [2:0] OFS_MSR = 3'h6;
    localparam logic [2:0] OFS_SPR = 3'h7;

    // ==========================================================
    // Field positions
    localparam int FCR_FIFO_EN = 0;
    localparam int FCR_BLOCK = 3;
    localparam int IER_RX = 0;
    localparam int IER_TX = 1;
    localparam int LCR_DIV_ACCESS = 7;
    localparam int MCR_IRQ_GATE = 3;
    localparam int LSR_DATA_READY = 0;
    localparam int LSR_TX_HOLD_EMPTY = 5;
    localparam int LSR_TX_ALL_EMPTY = 6;
    localparam int IDENT_FIFO_LO = 6;
    localparam int IDENT_FIFO_HI = 7;

    // ==========================================================
    // Reset values and identification codes
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] DIV_LOW_RST = 8'h01;
    localparam logic [7:0] DIV_HIGH_RST = 8'h00;
    localparam logic [7:0] IDENT_NONE = 8'h01;
    localparam logic [7:0] IDENT_RX = 8'h04;
    localparam logic [7:0] IDENT_TX = 8'h02;

    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESET_MIN_NS = 40;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // Types
    // Host bus pins, both bus styles
    typedef struct packed {
        logic bus_style_sel;       // 1 = separate strobes, 0 = read/write line
        logic chan_a_select_n;
        logic chan_b_select_n;
        logic chan_c_select_n;
        logic chan_d_select_n;
        logic chip_select_n;
        logic read_write_n;        // 1 = read, 0 = write
        logic read_strobe_n;
        logic write_strobe_n;
        logic chan_addr_hi;
        logic chan_addr_lo;
        logic [2:0] reg_addr;
        logic [7:0] wdata;
    } qhs_bus_t;

    // Status of one channel's datapath
    typedef struct packed {
        logic [4:0] tx_level;
        logic [4:0] tx_trig;
        logic [4:0] rx_level;
        logic [4:0] rx_trig;
        logic tsr_empty;
        logic rx_timeout;
        logic [7:0] rx_byte;
        logic [7:0] modem_in;
    } qhs_chan_stat_t;

    // Register set of one channel
    typedef struct packed {
        logic [7:0] irq_enable;
        logic [7:0] fifo_control;
        logic [7:0] line_control;
        logic [7:0] modem_control;
        logic [7:0] divisor_low;
        logic [7:0] divisor_high;
        logic [7:0] scratch_byte;
        logic rx_blk_n;
    } qhs_chan_regs_t;

    // Whole state of the host port
    typedef struct packed {
        qhs_chan_regs_t [3:0] chans;
        logic wr_prev;
        logic rd_prev;
        logic [7:0] rdata;
        logic rdata_oe;
        logic [3:0] irq;
        logic [3:0] rx_ready_n;
        logic [3:0] tx_ready_n;
        logic [3:0] tx_load;
        logic [3:0] rx_unload;
        logic [7:0] tx_byte;
    } qhs_state_t;

endpackage : qhs_pkg

// *** qhs_host_model.sv ***
// Host processor on the parallel bus: 8 data bits, 3 register address lines
module qhs_host_model (
    // Clock
    input wire logic mclk,
    // Bus toward the port
    output qhs_pkg::qhs_bus_t bus,
    input wire logic [7:0] rdata
);
    // ================
    // Bus cycles
    // Deselect all; flip write data so a stale byte never lingers
    task automatic release_bus;
        {bus.chan_a_select_n, bus.chan_b_select_n, bus.chan_c_select_n} = 3'h7;
        {bus.chan_d_select_n, bus.chip_select_n, bus.read_write_n} = 3'h7;
        {bus.read_strobe_n, bus.write_strobe_n} = 2'h3;
        bus.wdata = ~bus.wdata;
    endtask : release_bus

    // Present one access just after an edge, up to the next edge
    task automatic drive(input logic s, input logic [3:0] m, input logic rd, input logic [2:0] a,
                         input logic [7:0] wd);
        logic [1:0] n;
        n = m[3] ? 2'h3 : m[2] ? 2'h2 : m[1] ? 2'h1 : 2'h0;
        @(posedge mclk);
        #1;
        bus.bus_style_sel = s;
        bus.reg_addr = a;
        bus.wdata = wd;
        if (s) begin
            {bus.chan_d_select_n, bus.chan_c_select_n, bus.chan_b_select_n} = ~m[3:1];
            bus.chan_a_select_n = ~m[0];
            {bus.chan_addr_hi, bus.chan_addr_lo} = 2'($urandom);
            bus.read_strobe_n = !rd;
            bus.write_strobe_n = rd;
        end else begin
            {bus.chan_addr_hi, bus.chan_addr_lo} = n;
            bus.chip_select_n = 1'h0;
            bus.read_write_n = rd;
            {bus.chan_d_select_n, bus.chan_c_select_n, bus.chan_b_select_n} = 3'($urandom);
        end
        @(posedge mclk);
    endtask : drive

    // Write to every channel in the mask in strobe style; line style writes only the highest channel in the mask
    task automatic wr(input logic s, input logic [3:0] m, input logic [2:0] a, input logic [7:0] wd);
        drive(s, m, 1'h0, a, wd);
        #1;
        release_bus();
    endtask : wr

    // Read from one channel only; held a second cycle
    task automatic rd(input logic s, input int ch, input logic [2:0] a, output logic [7:0] q);
        drive(s, 4'(1 << ch), 1'h1, a, ~bus.wdata);
        #1;
        q = rdata;
        @(posedge mclk);
        #1;
        release_bus();
    endtask : rd

    // Idle bus from time zero
    initial begin
        bus = '0;
        bus.bus_style_sel = 1'h1;
        release_bus();
    end
endmodule : qhs_host_model

// *** qhs_host_port_checker.sv ***
module qhs_host_port_checker (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Host side
    input wire qhs_pkg::qhs_bus_t host_bus,
    input wire logic [7:0] rdata,
    input wire logic rdata_oe,
    input wire logic irq_style_select,
    // Channel side
    input wire qhs_pkg::qhs_chan_stat_t [3:0] chan_stat,
    input wire qhs_pkg::qhs_chan_regs_t [3:0] chan_cfg,
    input wire logic [7:0] tx_byte,
    input wire logic [3:0] tx_load,
    input wire logic [3:0] rx_unload,
    // Pins
    input wire logic [3:0] irq,
    input wire logic [3:0] rx_ready_n,
    input wire logic [3:0] tx_ready_n
);
    // ================
    // Decode
    logic st, rd_act, wr_act, wr_take, wr_prev_q;
    logic [3:0] sel_n, sel, blk, exp_irq;
    assign sel_n = {host_bus.chan_d_select_n, host_bus.chan_c_select_n,
                    host_bus.chan_b_select_n, host_bus.chan_a_select_n};

    // Selected channels, block mode and expected interrupt level
    always_comb begin
        st = host_bus.bus_style_sel;
        for (int c = 0; c < 4; c++) begin
            sel[c] = st ? !sel_n[c] : (!host_bus.chip_select_n &&
                {host_bus.chan_addr_hi, host_bus.chan_addr_lo} == 2'(c));
            blk[c] = chan_cfg[c].fifo_control[0] && chan_cfg[c].fifo_control[3];
            exp_irq[c] = ((chan_cfg[c].irq_enable[1] && (chan_stat[c].tx_level == 5'h0 ||
                (chan_cfg[c].fifo_control[0] && chan_stat[c].tx_level < chan_stat[c].tx_trig)))
                || (chan_cfg[c].irq_enable[0] && (chan_cfg[c].fifo_control[0] ?
                (chan_stat[c].rx_level >= chan_stat[c].rx_trig || chan_stat[c].rx_timeout) :
                chan_stat[c].rx_level != 5'h0)))
                && (!st || irq_style_select || chan_cfg[c].modem_control[3]);
        end
        rd_act = |sel && (st ? !host_bus.read_strobe_n : host_bus.read_write_n);
        wr_act = |sel && (st ? !host_bus.write_strobe_n : !host_bus.read_write_n);
        wr_take = wr_act && !wr_prev_q;
    end

    // Write seen at the previous edge
    always_ff @(posedge mclk) begin
        wr_prev_q <= rstn && wr_act;
    end

    // ================
    // Assertions
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    chk_reset_pins: assert property (disable iff (1'h0) !rstn |=> irq == 4'h0 &&
        rx_ready_n == 4'hf && tx_ready_n == 4'h0 && !rdata_oe) else $error("reset pins");
    chk_read_enable: assert property (1'h1 |=> rdata_oe == $past(rd_act))
        else $error("data bus drive wrong");
    for (genvar c = 0; c < 4; c++) begin : g_ch
        chk_irq_level: assert property (1'h1 |=> irq[c] == $past(exp_irq[c]))
            else $error("irq level wrong");
        chk_tx_single: assert property (!blk[c] |=> tx_ready_n[c] ==
            $past(chan_stat[c].tx_level != 5'h0)) else $error("tx ready wrong");
        chk_tx_block: assert property (blk[c] |=> tx_ready_n[c] ==
            $past(chan_stat[c].tx_level == qhs_pkg::FIFO_FULL)) else $error("tx block wrong");
        chk_rx_single: assert property (!blk[c] |=> rx_ready_n[c] ==
            $past(chan_stat[c].rx_level == 5'h0)) else $error("rx ready wrong");
        chk_rx_fall: assert property (blk[c] && chan_stat[c].rx_level != 5'h0 &&
            (chan_stat[c].rx_level >= chan_stat[c].rx_trig || chan_stat[c].rx_timeout)
            |=> !rx_ready_n[c]) else $error("rx block fall wrong");
        chk_rx_rise: assert property (blk[c] && chan_stat[c].rx_level == 5'h0 &&
            !chan_stat[c].rx_timeout |=> rx_ready_n[c]) else $error("rx block rise wrong");
        chk_write_scratch: assert property (wr_take && sel[c] &&
            host_bus.reg_addr == qhs_pkg::OFS_SPR |=> chan_cfg[c].scratch_byte ==
            $past(host_bus.wdata)) else $error("scratch write lost");
        chk_scratch_hold: assert property (!(wr_take && sel[c]) |=>
            $stable(chan_cfg[c].scratch_byte)) else $error("scratch changed");
        chk_tx_load: assert property (wr_take && sel[c] && host_bus.reg_addr ==
            qhs_pkg::OFS_DATA && !chan_cfg[c].line_control[7] |=> tx_load[c] &&
            tx_byte == $past(host_bus.wdata)) else $error("tx load wrong");
        chk_read_scratch: assert property (rd_act && sel == 4'(1 << c) &&
            host_bus.reg_addr == qhs_pkg::OFS_SPR |=> rdata ==
            $past(chan_cfg[c].scratch_byte)) else $error("scratch read wrong");
        chk_rx_unload: assert property (rd_act && !$past(rd_act) &&
            sel == 4'(1 << c) && host_bus.reg_addr == qhs_pkg::OFS_DATA &&
            !chan_cfg[c].line_control[7] |=> rx_unload[c]) else $error("rx unload missing");
    end

    // Main scenarios reached
    cov_broadcast: cover property (wr_take && sel == 4'hf);
    cov_rx_fall: cover property (blk[0] && $fell(rx_ready_n[0]));
    cov_line_read: cover property (rd_act && !st);
endmodule : qhs_host_port_checker

// *** tb.sv ***
module tb;
    timeunit 1ns;
    timeprecision 1ns;

    // ================
    // Signals
    logic mclk = 1'h0;
    logic rstn = 1'h0;
    logic isel = 1'h0;
    logic s;
    logic [7:0] d, v, rdata, tx_byte;
    logic rdata_oe;
    logic [3:0] tx_load, rx_unload, irq, rx_ready_n, tx_ready_n;
    int c;
    int errors = 0;
    int n_tests = 0;
    qhs_pkg::qhs_bus_t bus;
    qhs_pkg::qhs_chan_stat_t [3:0] stat = '0;
    qhs_pkg::qhs_chan_regs_t [3:0] rg = '0;
    qhs_pkg::qhs_chan_regs_t [3:0] cfg;
    logic [4:0] lv [7] = '{5'h3, 5'h4, 5'h2, 5'h0, 5'h1, 5'h1, 5'h0};
    logic [6:0] tmo = 7'h04;
    logic [2:0] ofs [4] = '{qhs_pkg::OFS_FCR, qhs_pkg::OFS_IER, qhs_pkg::OFS_MCR,
        qhs_pkg::OFS_DATA};
    logic [6:0] exr = 7'h49;

    // Clock
    always #5 mclk = ~mclk;

    // ================
    // Instances
    qhs_host_model u_host (.mclk(mclk), .bus(bus), .rdata(rdata));
    qhs_host_port uut (.mclk(mclk), .rstn(rstn), .host_bus(bus), .rdata(rdata),
        .rdata_oe(rdata_oe), .irq_style_select(isel), .chan_stat(stat), .chan_cfg(cfg),
        .tx_byte(tx_byte), .tx_load(tx_load), .rx_unload(rx_unload), .irq(irq),
        .rx_ready_n(rx_ready_n), .tx_ready_n(tx_ready_n));

    // ================
    // Helpers
    // Expected transmit ready level
    function automatic logic exp_tx(qhs_pkg::qhs_chan_regs_t r, logic [4:0] l);
        return (r.fifo_control[0] && r.fifo_control[3]) ? l == 5'h10 : l != 5'h0;
    endfunction : exp_tx

    // Expected interrupt level
    function automatic logic exp_irq(qhs_pkg::qhs_chan_regs_t r, qhs_pkg::qhs_chan_stat_t t);
        logic tx, rx;
        tx = t.tx_level == 5'h0 || (r.fifo_control[0] && t.tx_level < t.tx_trig);
        rx = r.fifo_control[0] ? t.rx_level >= t.rx_trig || t.rx_timeout : t.rx_level != 5'h0;
        return ((r.irq_enable[1] && tx) || (r.irq_enable[0] && rx)) &&
            (!bus.bus_style_sel || isel || r.modem_control[3]);
    endfunction : exp_irq

    // Compare and count
    task automatic check(input string what, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask : check

    // Write a register and track it
    task automatic set_reg(input logic ss, input int ch, input logic [2:0] a, input logic [7:0] x);
        u_host.wr(ss, 4'(1 << ch), a, x);
        case (a)
            qhs_pkg::OFS_IER: rg[ch].irq_enable = x;
            qhs_pkg::OFS_FCR: rg[ch].fifo_control = x;
            qhs_pkg::OFS_MCR: rg[ch].modem_control = x;
            qhs_pkg::OFS_SPR: rg[ch].scratch_byte = x;
            default: ;
        endcase
    endtask : set_reg

    // Verdict
    task automatic conclude;
        if (errors == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    // ================
    // Sequence
    // Hang guard
    initial begin
        #900000;
        errors++;
        conclude();
    end

    // Main run
    initial begin
        void'($urandom(32'hc0cdeebe));
        repeat (qhs_pkg::RESET_MIN_CYC + 1) @(posedge mclk);
        #1;
        check("tx_ready_n", 8'h00, 8'(tx_ready_n));
        check("rx_ready_n", 8'h0f, 8'(rx_ready_n));
        check("divisor_low", 8'h01, cfg[2].divisor_low);
        rstn = 1'h1;
        // Each channel in each style, read back in the other
        for (int k = 0; k < 2; k++) begin
            for (int ch = 0; ch < 4; ch++) set_reg(k[0], ch, qhs_pkg::OFS_SPR, 8'($urandom));
            for (int ch = 0; ch < 4; ch++) begin
                u_host.rd(!k[0], ch, qhs_pkg::OFS_SPR, d);
                check("scratch", rg[ch].scratch_byte, d);
            end
        end
        // One write to all four channels
        v = 8'($urandom);
        u_host.wr(1'h1, 4'hf, qhs_pkg::OFS_SPR, v);
        for (int ch = 0; ch < 4; ch++) begin
            u_host.rd(1'h0, ch, qhs_pkg::OFS_SPR, d);
            check("broadcast", v, d);
        end
        // Block receive ready: falls at trigger or timeout, rises only when empty
        set_reg(1'h1, 0, qhs_pkg::OFS_FCR, 8'h09);
        stat[0].rx_trig = 5'h4;
        for (int i = 0; i < 7; i++) begin
            stat[0].rx_level = lv[i];
            stat[0].rx_timeout = tmo[6-i];
            @(posedge mclk);
            #1;
            check("rx_ready_n block", 8'(exr[6-i]), 8'(rx_ready_n[0]));
        end
        // Random modes and levels on all channels
        repeat (300) begin
            c = $urandom_range(3);
            s = 1'($urandom);
            foreach (ofs[j]) set_reg(s, c, ofs[j], 8'($urandom));
            isel = 1'($urandom);
            for (int k = 0; k < 4; k++) begin
                stat[k] = qhs_pkg::qhs_chan_stat_t'({$urandom, $urandom});
                stat[k].tx_level = 5'($urandom_range(16));
                stat[k].rx_level = 5'($urandom_range(16));
                stat[k].tx_trig = 5'($urandom_range(16, 1));
                stat[k].rx_trig = 5'($urandom_range(16, 1));
            end
            @(posedge mclk);
            #1;
            for (int k = 0; k < 4; k++) begin
                check("tx_ready_n", 8'(exp_tx(rg[k], stat[k].tx_level)), 8'(tx_ready_n[k]));
                check("irq", 8'(exp_irq(rg[k], stat[k])), 8'(irq[k]));
            end
            u_host.rd(s, c, qhs_pkg::OFS_LSR, d);
            v = {1'h0, stat[c].tx_level == 5'h0 && stat[c].tsr_empty, stat[c].tx_level == 5'h0, 5'h0};
            check("line_status", v & 8'h60, d & 8'h60);
            u_host.rd(s, c, qhs_pkg::OFS_DATA, d);
            check("rx_holding", stat[c].rx_byte, d);
        end
        conclude();
    end
endmodule : tb

bind qhs_host_port qhs_host_port_checker u_chk (.mclk(mclk), .rstn(rstn), .host_bus(host_bus),
    .rdata(rdata), .rdata_oe(rdata_oe), .irq_style_select(irq_style_select),
    .chan_stat(chan_stat), .chan_cfg(chan_cfg), .tx_byte(tx_byte), .tx_load(tx_load),
    .rx_unload(rx_unload), .irq(irq), .rx_ready_n(rx_ready_n), .tx_ready_n(tx_ready_n));
